// ==== can_remote_frame_reply.sv ====
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// (RULE_01) ready tx center without request waits
// (RULE_02) accepted request sets transmit and external request
// (RULE_03) request copies dlc and identifier in
// (RULE_04) uninhibited reply sent, then both requests cleared
// (RULE_05) inhibit holds reply until software releases it
// (RULE_06) reply length equals request byte count
// (RULE_07) rx center sets external request, data updated
// (RULE_08) never set transmit request on rx center
// (RULE_09) center 15 cannot reply itself
// (RULE_10) software disables rx center before turning tx
// (RULE_11) software inhibits center before loading data
// (RULE_12) software arms reconfigured center in one write
// (RULE_13) software copies id, count to second center
// (RULE_14) software request sends without external request
// (RULE_15) software returns first center to receive
// (RULE_16) software leaves cleared transmit request alone
// (RULE_17) request keeps data bytes, changes count, id
// (RULE_18) masked id stored when masking enabled
// (RULE_19) unmasked request leaves arbitration effectively unchanged
// (RULE_20) software keeps masking off for remote centers
// (RULE_21) reply done sets success, optional irq
// (RULE_22) request writes no data bytes
module can_remote_frame_reply #(
  parameter int unsigned NC = rfr_pkg::NUM_CENTERS
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rfr_valid,
  input  wire logic [3:0]  rfr_center,
  input  wire logic [28:0] rfr_id,
  input  wire logic [3:0]  rfr_dlc,
  output logic             tx_start,
  output logic [3:0]       tx_center,
  output logic [28:0]      tx_id,
  output logic [3:0]       tx_dlc,
  output logic [63:0]      tx_data,
  input  wire logic        tx_done,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////
  // per-center state, then shared select, status and transmit state
  logic [NC-1:0]       ready_ff, data_updated_ff, tih_ff, treq_ff, xreq_ff, dir_ff, men_ff, tien_ff, ip_ff;
  logic [NC-1:0]       nxt_ready, nxt_data_updated, nxt_tih, nxt_treq, nxt_xreq, nxt_dir, nxt_men, nxt_tien, nxt_ip;
  logic [28:0]         arb_ff [NC];
  logic [28:0]         nxt_arb [NC];
  logic [28:0]         msk_ff [NC];
  logic [28:0]         nxt_msk [NC];
  logic [3:0]          dlc_ff [NC];
  logic [3:0]          nxt_dlc [NC];
  logic [63:0]         dat_ff [NC];
  logic [63:0]         nxt_dat [NC];
  logic [3:0]          sel_ff, nxt_sel;
  logic                txs_ff, nxt_txs;
  logic                busy_ff, nxt_busy;
  logic [3:0]          cur_ff, nxt_cur;
  logic                start_ff, nxt_start;
  logic                irq_ff, nxt_irq;
  logic [28:0]         fid_ff, nxt_fid;
  logic [3:0]          fdlc_ff, nxt_fdlc;
  logic [63:0]         fdat_ff, nxt_fdat;

  ////////////////////////////////////////////////////////////////////////
  // axi-lite slave
  logic        awr_ff, nxt_awr, wr_ff, nxt_wr, bv_ff, nxt_bv, arr_ff, nxt_arr, rv_ff, nxt_rv;
  logic [11:0] awa_ff, nxt_awa;
  logic [31:0] wd_ff, nxt_wd, rd_ff, nxt_rd;
  logic [1:0]  br_ff, nxt_br, rr_ff, nxt_rr;
  logic        aw_have_ff, nxt_aw_have, w_have_ff, nxt_w_have;
  logic        do_wr;
  logic [3:0]  sel_idx;

  assign sel_idx = (sel_ff < 4'(NC)) ? sel_ff : 4'h0;
  assign do_wr   = aw_have_ff && w_have_ff && !bv_ff;

  always_comb begin
    nxt_aw_have = aw_have_ff;
    nxt_w_have  = w_have_ff;
    nxt_awa     = awa_ff;
    nxt_wd      = wd_ff;
    nxt_bv      = bv_ff;
    nxt_br      = br_ff;
    if (s_axi_awvalid && awr_ff) begin
      nxt_aw_have = 1'b1;
      nxt_awa     = s_axi_awaddr;
    end
    if (s_axi_wvalid && wr_ff) begin
      nxt_w_have = 1'b1;
      nxt_wd     = s_axi_wdata;
    end
    if (do_wr) begin
      nxt_aw_have = 1'b0;
      nxt_w_have  = 1'b0;
      nxt_bv      = 1'b1;
      nxt_br      = (awa_ff <= rfr_pkg::OFS_STATUS && awa_ff[1:0] == 2'b00) ? rfr_pkg::RESP_OKAY
                                                                           : rfr_pkg::RESP_SLVERR;
    end
    if (bv_ff && s_axi_bready) begin
      nxt_bv = 1'b0;
    end
    nxt_awr = !nxt_aw_have && !nxt_bv;
    nxt_wr  = !nxt_w_have && !nxt_bv;
    nxt_rv  = rv_ff;
    nxt_rd  = rd_ff;
    nxt_rr  = rr_ff;
    if (rv_ff && s_axi_rready) begin
      nxt_rv = 1'b0;
    end
    if (s_axi_arvalid && arr_ff) begin
      nxt_rv = 1'b1;
      nxt_rr = rfr_pkg::RESP_OKAY;
      case (s_axi_araddr)
        rfr_pkg::OFS_SEL:     nxt_rd = {28'h000_0000, sel_ff};
        rfr_pkg::OFS_CTRL:    nxt_rd = {16'h0000, dlc_ff[sel_idx], 3'b000, ip_ff[sel_idx], tien_ff[sel_idx],
                                        men_ff[sel_idx], dir_ff[sel_idx], xreq_ff[sel_idx], treq_ff[sel_idx],
                                        tih_ff[sel_idx], data_updated_ff[sel_idx], ready_ff[sel_idx]};
        rfr_pkg::OFS_ARB:     nxt_rd = {3'b000, arb_ff[sel_idx]};
        rfr_pkg::OFS_MASK:    nxt_rd = {3'b000, msk_ff[sel_idx]};
        rfr_pkg::OFS_DATA_LO: nxt_rd = dat_ff[sel_idx][31:0];
        rfr_pkg::OFS_DATA_HI: nxt_rd = dat_ff[sel_idx][63:32];
        rfr_pkg::OFS_STATUS:  nxt_rd = {30'h0000_0000, busy_ff, txs_ff};
        default: begin
          nxt_rd = 32'h0000_0000;
          nxt_rr = rfr_pkg::RESP_SLVERR;
        end
      endcase
    end
    nxt_arr = !nxt_rv;
  end

  ////////////////////////////////////////////////////////////////////////
  // center state, request acceptance, transmit scheduler
  logic [NC-1:0] eligible;
  logic          found;
  logic [3:0]    pick;
  logic [NC-1:0] rfr_hit;
  logic [63:0]   tx_mask;

  always_comb begin
    found = 1'b0;
    pick  = 4'h0;
    for (int i = 0; i < NC; i++) begin
      // tx only when request pending, ready, updated, not inhibited
      eligible[i] = dir_ff[i] && ready_ff[i] && data_updated_ff[i] && !tih_ff[i] && treq_ff[i]; // [RULE_01] [RULE_05] [RULE_14]
      rfr_hit[i]  = rfr_valid && (rfr_center == 4'(i)) && ready_ff[i];
      if (eligible[i] && !found) begin
        found = 1'b1;
        pick  = 4'(i);
      end
    end
  end

  always_comb begin
    nxt_ready = ready_ff; nxt_data_updated = data_updated_ff; nxt_tih = tih_ff; nxt_treq = treq_ff; nxt_xreq = xreq_ff;
    nxt_dir = dir_ff; nxt_men = men_ff; nxt_tien = tien_ff; nxt_ip = ip_ff;
    nxt_arb = arb_ff; nxt_msk = msk_ff; nxt_dlc = dlc_ff; nxt_dat = dat_ff;
    nxt_sel = sel_ff; nxt_txs = txs_ff; nxt_busy = busy_ff; nxt_cur = cur_ff;
    nxt_start = 1'b0; nxt_irq = |ip_ff;
    nxt_fid   = fid_ff;
    nxt_fdlc  = fdlc_ff;
    nxt_fdat  = fdat_ff;
    // software writes first; hardware events below win
    if (do_wr && s_axi_wstrb[0]) begin
      case (awa_ff)
        rfr_pkg::OFS_SEL:  nxt_sel = wd_ff[3:0];
        rfr_pkg::OFS_CTRL: begin
          nxt_ready[sel_idx] = wd_ff[rfr_pkg::B_READY];
          nxt_data_updated[sel_idx]  = wd_ff[rfr_pkg::B_DATA_UPDATED];
          nxt_tih[sel_idx]   = wd_ff[rfr_pkg::B_TIH];
          nxt_treq[sel_idx]  = wd_ff[rfr_pkg::B_TREQ];
          nxt_xreq[sel_idx]  = wd_ff[rfr_pkg::B_XREQ];
          nxt_dir[sel_idx]   = (sel_idx == 4'(rfr_pkg::LAST_CENTER - 1)) ? 1'b0 : wd_ff[rfr_pkg::B_DIR_TX]; // [RULE_09]
          nxt_men[sel_idx]   = wd_ff[rfr_pkg::B_MASK_EN];
          nxt_tien[sel_idx]  = wd_ff[rfr_pkg::B_TX_IRQ_EN];
          if (wd_ff[rfr_pkg::B_IRQ_PEND]) nxt_ip[sel_idx] = 1'b0;
          nxt_dlc[sel_idx]   = wd_ff[rfr_pkg::B_DLC_LO +: 4];
        end
        rfr_pkg::OFS_ARB:     nxt_arb[sel_idx] = wd_ff[28:0];
        rfr_pkg::OFS_MASK:    nxt_msk[sel_idx] = wd_ff[28:0];
        rfr_pkg::OFS_DATA_LO: nxt_dat[sel_idx][31:0] = wd_ff;
        rfr_pkg::OFS_DATA_HI: nxt_dat[sel_idx][63:32] = wd_ff;
        rfr_pkg::OFS_STATUS:  if (wd_ff[rfr_pkg::S_TXS]) nxt_txs = 1'b0;
        default: nxt_sel = sel_ff;
      endcase
    end
    for (int i = 0; i < NC; i++) begin
      if (rfr_hit[i]) begin
        nxt_dlc[i]  = rfr_dlc;                                          // [RULE_03] [RULE_17]
        nxt_arb[i]  = men_ff[i] ? (rfr_id & msk_ff[i]) : rfr_id;        // [RULE_18] [RULE_19]
        nxt_xreq[i] = 1'b1;                                             // [RULE_02] [RULE_07]
        if (dir_ff[i]) nxt_treq[i] = 1'b1;                              // [RULE_02]
        else           nxt_data_updated[i] = 1'b1;                              // [RULE_07] [RULE_08]
        // data bytes deliberately untouched
      end                                                               // [RULE_22]
    end
    if (busy_ff && tx_done) begin
      nxt_busy = 1'b0;
      nxt_treq[cur_ff] = 1'b0;                                          // [RULE_04] [RULE_14]
      nxt_xreq[cur_ff] = 1'b0;                                          // [RULE_04]
      nxt_txs = 1'b1;                                                   // [RULE_21]
      if (tien_ff[cur_ff]) nxt_ip[cur_ff] = 1'b1;                       // [RULE_21]
    end else if (!busy_ff && found) begin
      nxt_busy  = 1'b1;                                                 // [RULE_04]
      nxt_cur   = pick;
      nxt_start = 1'b1;
      // frozen at start: a late request cannot reshape a sent frame
      nxt_fid   = arb_ff[pick];
      nxt_fdlc  = dlc_ff[pick];                                         // [RULE_06]
      nxt_fdat  = dat_ff[pick] & tx_mask;                               // [RULE_17]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awr_ff <= 1'b0;
      wr_ff <= 1'b0;
      bv_ff <= 1'b0;
      arr_ff <= 1'b0;
      rv_ff <= 1'b0;
      awa_ff <= 12'h000;
      wd_ff <= 32'h0000_0000;
      rd_ff <= 32'h0000_0000;
      br_ff <= 2'b00;
      rr_ff <= 2'b00;
      aw_have_ff <= 1'b0;
      w_have_ff <= 1'b0;
      ready_ff <= '0;
      data_updated_ff <= '0;
      tih_ff <= '0;
      treq_ff <= '0;
      xreq_ff <= '0;
      dir_ff <= '0;
      men_ff <= '0;
      tien_ff <= '0;
      ip_ff <= '0;
      for (int i = 0; i < NC; i++) begin
        arb_ff[i] <= '0;
        msk_ff[i] <= '0;
        dlc_ff[i] <= '0;
        dat_ff[i] <= '0;
      end
      sel_ff <= 4'h0;
      txs_ff <= 1'b0;
      busy_ff <= 1'b0;
      cur_ff <= 4'h0;
      start_ff <= 1'b0;
      irq_ff <= 1'b0;
      fid_ff <= 29'h0000_0000;
      fdlc_ff <= 4'h0;
      fdat_ff <= 64'h0000_0000_0000_0000;
    end else begin
      awr_ff <= nxt_awr;
      wr_ff <= nxt_wr;
      bv_ff <= nxt_bv;
      arr_ff <= nxt_arr;
      rv_ff <= nxt_rv;
      awa_ff <= nxt_awa;
      wd_ff <= nxt_wd;
      rd_ff <= nxt_rd;
      br_ff <= nxt_br;
      rr_ff <= nxt_rr;
      aw_have_ff <= nxt_aw_have;
      w_have_ff <= nxt_w_have;
      ready_ff <= nxt_ready;
      data_updated_ff <= nxt_data_updated;
      tih_ff <= nxt_tih;
      treq_ff <= nxt_treq;
      xreq_ff <= nxt_xreq;
      dir_ff <= nxt_dir;
      men_ff <= nxt_men;
      tien_ff <= nxt_tien;
      ip_ff <= nxt_ip;
      arb_ff <= nxt_arb;
      msk_ff <= nxt_msk;
      dlc_ff <= nxt_dlc;
      dat_ff <= nxt_dat;
      sel_ff <= nxt_sel;
      txs_ff <= nxt_txs;
      busy_ff <= nxt_busy;
      cur_ff <= nxt_cur;
      start_ff <= nxt_start;
      irq_ff <= nxt_irq;
      fid_ff <= nxt_fid;
      fdlc_ff <= nxt_fdlc;
      fdat_ff <= nxt_fdat;
    end
  end

  // reply carries byte count from the request, data masked beyond it
  always_comb begin
    for (int b = 0; b < 8; b++) tx_mask[b*8 +: 8] = (4'(b) < dlc_ff[pick]) ? 8'hFF : 8'h00; // [RULE_06] [RULE_17]
  end

  assign s_axi_awready = awr_ff;
  assign s_axi_wready  = wr_ff;
  assign s_axi_bvalid  = bv_ff;
  assign s_axi_bresp   = br_ff;
  assign s_axi_arready = arr_ff;
  assign s_axi_rvalid  = rv_ff;
  assign s_axi_rdata   = rd_ff;
  assign s_axi_rresp   = rr_ff;
  assign tx_start      = start_ff;
  assign tx_center     = cur_ff;
  assign tx_id         = fid_ff;
  assign tx_dlc        = fdlc_ff;                                        // [RULE_06]
  assign tx_data       = fdat_ff;
  assign irq           = irq_ff;

endmodule // can_remote_frame_reply
`default_nettype wire

// ==== rfr_pkg.sv ====
package rfr_pkg;
  localparam int unsigned NUM_CENTERS  = 15;
  localparam int unsigned ID_W         = 29;
  localparam int unsigned DLC_W        = 4;
  localparam int unsigned AXI_AW       = 12;
  // register offsets
  localparam logic [11:0] OFS_SEL      = 12'h0_000;
  localparam logic [11:0] OFS_CTRL     = 12'h0_004;
  localparam logic [11:0] OFS_ARB      = 12'h0_008;
  localparam logic [11:0] OFS_MASK     = 12'h0_00C;
  localparam logic [11:0] OFS_DATA_LO  = 12'h0_010;
  localparam logic [11:0] OFS_DATA_HI  = 12'h0_014;
  localparam logic [11:0] OFS_STATUS   = 12'h0_018;
  // control field positions
  localparam int unsigned B_READY      = 0;
  localparam int unsigned B_DATA_UPDATED       = 1;
  localparam int unsigned B_TIH        = 2;
  localparam int unsigned B_TREQ       = 3;
  localparam int unsigned B_XREQ       = 4;
  localparam int unsigned B_DIR_TX     = 5;
  localparam int unsigned B_MASK_EN    = 6;
  localparam int unsigned B_TX_IRQ_EN  = 7;
  localparam int unsigned B_IRQ_PEND   = 8;
  localparam int unsigned B_DLC_LO     = 12;
  // status field positions
  localparam int unsigned S_TXS        = 0;
  localparam int unsigned S_TX_BUSY    = 1;
  localparam logic [31:0] RST_CTRL     = 32'h0000_0000;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;
  localparam int unsigned LAST_CENTER  = 15;
endpackage

// ==== rfr_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module rfr_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        tx_start,
  input wire logic [28:0] tx_id,
  input wire logic [3:0]  tx_dlc,
  input wire logic [63:0] tx_data,
  input wire logic        tx_done,
  input wire logic        irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  //////////////////////////////////////////
  sequence s_wr_in; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_busy; tx_start ##1 !tx_done; endsequence
  property p_tx_once; tx_start |=> !tx_start until tx_done; endproperty
  a_tx_once: assert property (p_tx_once) else $error("second start while busy");
  property p_hold; s_busy |-> $stable(tx_id) && $stable(tx_dlc) && $stable(tx_data); endproperty
  a_hold: assert property (p_hold) else $error("frame moved while busy");
  property p_tail; tx_start && tx_dlc < 4'h8 |-> (tx_data >> {tx_dlc, 3'b000}) == 64'h0; endproperty
  a_tail: assert property (p_tail) else $error("bytes past count");
  property p_irq; $rose(irq) |-> $past(tx_done) || $past(tx_done, 2); endproperty
  a_irq: assert property (p_irq) else $error("irq without send");
  property p_bresp; s_wr_in |-> ##[1:2] s_axi_bvalid; endproperty
  a_bresp: assert property (p_bresp) else $error("no write answer");
  property p_bonce; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bonce: assert property (p_bonce) else $error("write answer twice");
  property p_rresp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rresp: assert property (p_rresp) else $error("no read answer");
  property p_ronce; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_ronce: assert property (p_ronce) else $error("read answer twice");
endmodule // rfr_chk
bind can_remote_frame_reply rfr_chk watch (.*);
`default_nettype wire

// ==== rfr_far_node.sv ====
`timescale 1ns/1ps
`default_nettype none
module rfr_far_node (
  input wire logic        aclk,
  input wire logic [7:0]  lag,
  input wire logic        tx_start,
  input wire logic [28:0] tx_id,
  input wire logic [3:0]  tx_dlc,
  input wire logic [63:0] tx_data,
  output logic            tx_done,
  output logic [28:0]     got_id,
  output logic [3:0]      got_dlc,
  output logic [63:0]     got_data,
  output int              n_got
);
  // a long lag keeps the frame busy so software can look mid-send
  initial begin
    tx_done = 1'b0;
    n_got = 0;
    forever begin
      @(posedge aclk);
      if (tx_start) begin
        got_id <= tx_id;
        got_dlc <= tx_dlc;
        got_data <= tx_data;
        repeat (lag) @(posedge aclk);
        tx_done <= 1'b1;
        n_got <= n_got + 1;
        @(posedge aclk);
        tx_done <= 1'b0;
      end
    end
  end
endmodule // rfr_far_node
`default_nettype wire

// ==== can_remote_frame_reply_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module can_remote_frame_reply_tb_top;
  localparam logic [31:0] one = 32'h0000_0001, cnt = 32'h0000_F000, idm = 32'h1FFF_FFFF;
  localparam logic [31:0] rdy = one << rfr_pkg::B_READY, dup = one << rfr_pkg::B_DATA_UPDATED;
  localparam logic [31:0] inh = one << rfr_pkg::B_TIH, trq = one << rfr_pkg::B_TREQ;
  localparam logic [31:0] xrq = one << rfr_pkg::B_XREQ, dir = one << rfr_pkg::B_DIR_TX;
  localparam logic [31:0] men = one << rfr_pkg::B_MASK_EN, tie = one << rfr_pkg::B_TX_IRQ_EN;
  localparam logic [31:0] pnd = one << rfr_pkg::B_IRQ_PEND;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, rfr_valid = 1'b0, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, tx_start, tx_done, irq;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata, r;
  logic [3:0] s_axi_wstrb = 4'hF, rfr_center = 4'h0, rfr_dlc = 4'h0, tx_center, tx_dlc, got_dlc;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, wb;
  logic [28:0] rfr_id = 29'h0000_0000, tx_id, got_id;
  logic [63:0] tx_data, got_data;
  logic [7:0] lag = 8'h02;
  int n_mismatch = 0, compares = 0, n_got;
  can_remote_frame_reply dut (.*);
  rfr_far_node far (.*);
  initial forever #4 aclk = ~aclk;
  //////////////////////////////////////////
  function automatic logic [31:0] dl(input int n);
    return 32'(n) << rfr_pkg::B_DLC_LO;
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    wb = s_axi_bresp;
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    r = s_axi_rdata;
    rr = s_axi_rresp;
    chk(64'(r & m), 64'(e));
  endtask
  // idle request lines show the inverse, never a stale match
  task automatic req(input logic [3:0] c, input logic [28:0] id, input logic [3:0] n);
    @(posedge aclk);
    rfr_valid <= 1'b1;
    rfr_center <= c;
    rfr_id <= id;
    rfr_dlc <= n;
    @(posedge aclk);
    rfr_valid <= 1'b0;
    rfr_center <= ~c;
    rfr_id <= ~id;
    rfr_dlc <= ~n;
  endtask
  task automatic frame(input int k);
    for (int i = 0; i < 400 && n_got < k; i++) @(posedge aclk);
    chk(64'(n_got), 64'(k));
  endtask
  //////////////////////////////////////////
  task automatic t_regs();
    rc(rfr_pkg::OFS_CTRL, 32'hFFFF_FFFF, rfr_pkg::RST_CTRL);
    chk(64'(rr), 64'(rfr_pkg::RESP_OKAY));
    rc(12'h0_FFC, 32'hFFFF_FFFF, 32'h0000_0000);
    chk(64'(rr), 64'(rfr_pkg::RESP_SLVERR));
    wr(12'h0_FFC, 32'h0000_0000);
    chk(64'(wb), 64'(rfr_pkg::RESP_SLVERR));
    wr(rfr_pkg::OFS_SEL, 32'h0000_0000);
    chk(64'(wb), 64'(rfr_pkg::RESP_OKAY));
    $display("regs done");
  endtask
  task automatic t_auto();
    lag <= 8'h28;
    wr(rfr_pkg::OFS_SEL, 32'h0000_0001);
    wr(rfr_pkg::OFS_CTRL, dir | inh);
    wr(rfr_pkg::OFS_DATA_LO, 32'h2E43_AF75);
    wr(rfr_pkg::OFS_DATA_HI, 32'h0090_7812);
    wr(rfr_pkg::OFS_CTRL, dir | rdy | dup | tie | dl(5));
    repeat (20) @(posedge aclk);
    chk(64'(n_got), 64'h0);
    req(4'h1, 29'h0123_4567, 4'h2);
    rc(rfr_pkg::OFS_CTRL, trq | xrq | cnt, trq | xrq | dl(2));
    rc(rfr_pkg::OFS_ARB, idm, 32'h0123_4567);
    frame(1);
    chk(64'(got_dlc), 64'h2);
    chk(got_data, 64'h0000_0000_0000_AF75);
    chk(64'(got_id), 64'h0123_4567);
    chk(64'(tx_center), 64'h1);
    rc(rfr_pkg::OFS_CTRL, trq | xrq | pnd, pnd);
    rc(rfr_pkg::OFS_STATUS, one, one);
    chk(64'(irq), 64'h1);
    rc(rfr_pkg::OFS_DATA_LO, 32'hFFFF_FFFF, 32'h2E43_AF75);
    wr(rfr_pkg::OFS_CTRL, dir | pnd);
    repeat (2) @(posedge aclk);
    chk(64'(irq), 64'h0);
    $display("auto done");
  endtask
  task automatic t_hold();
    lag <= 8'h01;
    wr(rfr_pkg::OFS_SEL, 32'h0000_0002);
    wr(rfr_pkg::OFS_CTRL, dir | rdy | dup | inh | dl(8));
    req(4'h2, 29'h1555_0002, 4'h3);
    repeat (20) @(posedge aclk);
    chk(64'(n_got), 64'h1);
    wr(rfr_pkg::OFS_CTRL, dir | rdy | dup | trq | xrq | dl(3));
    frame(2);
    chk(64'(got_dlc), 64'h3);
    chk(64'(got_id), 64'h1555_0002);
    $display("hold done");
  endtask
  task automatic t_rx();
    wr(rfr_pkg::OFS_SEL, 32'h0000_0003);
    wr(rfr_pkg::OFS_CTRL, rdy);
    req(4'h3, 29'h0000_0ABC, 4'h4);
    rc(rfr_pkg::OFS_CTRL, rdy | dup | trq | xrq | dir | cnt, rdy | dup | xrq | dl(4));
    wr(rfr_pkg::OFS_CTRL, dup | xrq | dl(4));
    wr(rfr_pkg::OFS_SEL, 32'h0000_0004);
    wr(rfr_pkg::OFS_CTRL, dir | inh | dl(4));
    wr(rfr_pkg::OFS_ARB, 32'h0000_0ABC);
    wr(rfr_pkg::OFS_DATA_LO, 32'h4433_2211);
    wr(rfr_pkg::OFS_CTRL, dir | rdy | dup | trq | dl(4));
    frame(3);
    chk(got_data, 64'h0000_0000_4433_2211);
    chk(64'(got_id), 64'h0ABC);
    chk(64'(tx_center), 64'h4);
    rc(rfr_pkg::OFS_CTRL, trq | xrq, 32'h0000_0000);
    wr(rfr_pkg::OFS_SEL, 32'h0000_0003);
    wr(rfr_pkg::OFS_CTRL, rdy);
    $display("rx done");
  endtask
  task automatic t_same();
    req(4'h3, 29'h0000_0DEF, 4'h3);
    wr(rfr_pkg::OFS_CTRL, dup | xrq | dl(3));
    wr(rfr_pkg::OFS_CTRL, dir | dup | xrq | dl(3));
    wr(rfr_pkg::OFS_CTRL, dir | inh | xrq | dl(3));
    wr(rfr_pkg::OFS_DATA_LO, 32'h8877_6655);
    wr(rfr_pkg::OFS_CTRL, dir | rdy | dup | trq | xrq | dl(3));
    frame(4);
    chk(got_data, 64'h0000_0000_0077_6655);
    chk(64'(got_id), 64'h0DEF);
    rc(rfr_pkg::OFS_CTRL, trq | xrq, 32'h0000_0000);
    $display("same center done");
  endtask
  task automatic t_last();
    wr(rfr_pkg::OFS_SEL, 32'h0000_000E);
    wr(rfr_pkg::OFS_CTRL, dir | rdy);
    rc(rfr_pkg::OFS_CTRL, dir, 32'h0000_0000);
    wr(rfr_pkg::OFS_CTRL, 32'h0000_0000);
    $display("last center done");
  endtask
  task automatic t_mask();
    wr(rfr_pkg::OFS_SEL, 32'h0000_0005);
    wr(rfr_pkg::OFS_MASK, 32'h1FFF_FF00);
    wr(rfr_pkg::OFS_CTRL, dir | rdy | dup | inh | men);
    req(4'h5, 29'h0ABC_DEFF, 4'h1);
    rc(rfr_pkg::OFS_ARB, idm, 32'h0ABC_DE00);
    $display("mask done");
  endtask
  //////////////////////////////////////////
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    $display("unexpected at %0t: watchdog", $time);
    end_of_test();
  end
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_auto();
    t_hold();
    t_rx();
    t_same();
    t_last();
    t_mask();
    end_of_test();
  end
endmodule // can_remote_frame_reply_tb_top
`default_nettype wire
